/* inc/io_sample_frame_builder_defines.svh */
// Constants for the I/O sample frame builder
`ifndef IO_SAMPLE_FRAME_BUILDER_DEFINES_SVH
`define IO_SAMPLE_FRAME_BUILDER_DEFINES_SVH

`define START_DELIMITER 8'h7E
`define OFFSET_START 5'h00
`define FRAME_TYPE_IO_SAMPLE 8'h92
`define API_OUTPUT_STANDARD 8'h00
`define FIXED_BODY_LENGTH 16'h0010
`define TYPE_OFFSET 5'h03
`define LONG_ADDR_FIRST 5'h04
`define LONG_ADDR_LAST 5'h0B
`define OFFSET_LENGTH_HI 5'h01
`define OFFSET_LENGTH_LO 5'h02
`define OFFSET_NET_HI 5'h0C
`define OFFSET_NET_LO 5'h0D
`define OFFSET_OPTIONS 5'h0E
`define OFFSET_COUNT 5'h0F
`define OFFSET_DMASK_HI 5'h10
`define OFFSET_DMASK_LO 5'h11
`define OFFSET_AMASK 5'h12
`define HEADER_LAST 5'h12
`define DIGITAL_VALID_MASK 16'h7FFF
`define ANALOG_VALID_MASK 8'h8F
`define SUPPLY_BIT 7
`define OPT_ACKED_BIT 0
`define OPT_BROADCAST_BIT 1
`define CHECKSUM_BASE 8'hFF
`define WORD_DIGITAL 3'h0
`define WORD_NONE 3'h6
`define WORD_COUNT 6
`define SAMPLE_FIFO_DEPTH 8

`endif

/* inc/io_sample_frame_pkg.sv */
// Types shared by the I/O sample frame builder
`default_nettype none
package io_sample_frame_pkg;

    // Sample contents from the radio receive path
    typedef struct packed {
        logic [63:0] src_long;
        logic [15:0] src_net;
        logic acked;
        logic broadcast;
        logic [7:0] sample_count;
        logic [15:0] dig_mask;
        logic [7:0] ana_mask;
        logic [15:0] dig_samples;
        logic [4:0][15:0] ana_samples; // 0..3 analog inputs, 4 supply
    } io_sample_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_HEADER,
        PH_WORDS,
        PH_CHECKSUM
    } build_phase_t;

    typedef struct packed {
        build_phase_t phase;
        logic [4:0] idx;
        logic [2:0] word;
        logic low_half;
        logic [5:0] present;
        logic [5:0][15:0] words;
        logic [63:0] src_long;
        logic [15:0] src_net;
        logic [7:0] options;
        logic [7:0] sample_count;
        logic [15:0] dig_mask;
        logic [7:0] ana_mask;
        logic [15:0] length;
        logic [7:0] sum;
        logic sample_ready;
        logic busy;
        logic frame_done;
        logic dropped;
    } builder_state_t;

endpackage

`default_nettype wire

/* logic/io_sample_frame_builder.sv */
// I/O sample indicator frame builder and its output byte FIFO
//
// Summary of operation
// R1: Frame emitted on remote I/O sample when API output options equal zero.
// R2: Samples forwarded only in API mode; otherwise dropped silently.
// R3: Byte offset zero carries the one-byte start delimiter.
// R4: Start delimiter value is 0x7E.
// R5: Sixteen-bit length at offset 1 counts bytes between length and checksum.
// R6: Multi-byte fields go out most significant byte first.
// R7: Offset 3 carries frame type 0x92.
// R8: Offsets 4 to 11 carry the sender's 64-bit address.
// R9: Offsets 12 and 13 carry the sender's 16-bit network address.
// R10: Offset 14 options: bit 0 acknowledged, bit 1 broadcast, both allowed.
// R11: Offset 15 carries the number of sample sets.
// R12: Offset 16 digital mask covers lines 0 to 14; bit 15 unused.
// R13: Offset 18 analog mask: bits 0-3 inputs, bit 7 supply voltage.
// R14: Digital samples word present only when digital mask is nonzero.
// R15: Digital sample bits match mask positions; unsampled lines read zero.
// R16: One 16-bit word per enabled analog input, input 0 first.
// R17: Supply-voltage word follows the last analog word, before checksum.
// R18: Checksum is 0xFF minus low byte of sum from offset 3 onward.
`timescale 1ns/1ps
`include "io_sample_frame_builder_defines.svh"
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SAMPLE_FIFO_DEPTH
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
        logic in_ready;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;

    // Output stage is a register so the stream port comes from flops
    always_comb begin
        logic push;
        logic load;
        push = in_valid_in && st.in_ready;
        load = (!st.out_valid || out_ready_in) && (st.count != '0);
        next_st = st;
        if (st.out_valid && out_ready_in) begin
            next_st.out_valid = 1'b0;
        end
        if (load) begin
            next_st.out_valid = 1'b1;
            next_st.out_data = st.mem[st.rd];
            next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : PW'(st.rd + 1'b1);
        end
        if (push) begin
            next_st.mem[st.wr] = in_data_in;
            next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : PW'(st.wr + 1'b1);
        end
        next_st.count = CW'(st.count + CW'(push) - CW'(load));
        // Ready is registered and exact, so the source stalls when full
        next_st.in_ready = (next_st.count < CW'(DEPTH));
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_out = st.in_ready;
    assign out_valid_out = st.out_valid;
    assign out_data_out = st.out_data;
endmodule

module io_sample_frame_builder
    import io_sample_frame_pkg::*;
#(
    parameter int FIFO_DEPTH = `SAMPLE_FIFO_DEPTH
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic api_mode_in,
    input wire logic [7:0] api_output_options_in,
    input wire logic sample_valid_in,
    input wire io_sample_t sample_in,
    output logic sample_ready_out,
    output logic [7:0] tx_data_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    output logic busy_out,
    output logic frame_done_out,
    output logic frame_dropped_out
);
    builder_state_t st;
    builder_state_t next_st;
    logic fifo_ready;
    logic [7:0] frame_byte;
    logic push;

    // First present word at or after start, or none
    function automatic logic [2:0] next_word(input logic [5:0] pres,
                                             input logic [2:0] start);
        logic [2:0] found;
        found = `WORD_NONE;
        for (int i = `WORD_COUNT - 1; i >= 0; i--) begin
            if (pres[i] && (3'(i) >= start)) begin
                found = 3'(i);
            end
        end
        return found;
    endfunction

    // Byte for the current position of the frame
    always_comb begin
        logic [2:0] sel;
        sel = 3'(`LONG_ADDR_LAST - st.idx);
        frame_byte = 8'h00;
        case (st.phase)
            PH_HEADER: begin
                if (st.idx >= `LONG_ADDR_FIRST &&
                    st.idx <= `LONG_ADDR_LAST) begin
                    frame_byte = st.src_long[sel*8 +: 8]; // see R8, R6
                end else begin
                    case (st.idx)
                        `OFFSET_START:
                            frame_byte = `START_DELIMITER; // see R3, R4
                        `OFFSET_LENGTH_HI:
                            frame_byte = st.length[15:8]; // see R5
                        `OFFSET_LENGTH_LO:
                            frame_byte = st.length[7:0]; // see R5
                        `TYPE_OFFSET:
                            frame_byte = `FRAME_TYPE_IO_SAMPLE; // see R7
                        `OFFSET_NET_HI:
                            frame_byte = st.src_net[15:8]; // see R9
                        `OFFSET_NET_LO:
                            frame_byte = st.src_net[7:0]; // see R9
                        `OFFSET_OPTIONS:
                            frame_byte = st.options; // see R10
                        `OFFSET_COUNT:
                            frame_byte = st.sample_count; // see R11
                        `OFFSET_DMASK_HI:
                            frame_byte = st.dig_mask[15:8]; // see R12
                        `OFFSET_DMASK_LO:
                            frame_byte = st.dig_mask[7:0]; // see R12
                        `OFFSET_AMASK:
                            frame_byte = st.ana_mask; // see R13
                        default: frame_byte = 8'h00;
                    endcase
                end
            end
            PH_WORDS: begin
                // High byte first for every sample word
                frame_byte = st.low_half ? st.words[st.word][7:0]
                                         : st.words[st.word][15:8]; // see R6
            end
            PH_CHECKSUM: begin
                frame_byte = `CHECKSUM_BASE - st.sum; // see R18
            end
            default: frame_byte = 8'h00;
        endcase
    end

    assign push = (st.phase != PH_IDLE) && fifo_ready;

    always_comb begin
        logic [15:0] dmask;
        logic [7:0] amask;
        logic [5:0] pres;
        logic [3:0] nwords;
        logic [2:0] w;
        dmask = sample_in.dig_mask & `DIGITAL_VALID_MASK;
        amask = sample_in.ana_mask & `ANALOG_VALID_MASK;
        pres = {amask[`SUPPLY_BIT], amask[3:0], |dmask}; // see R14, R16, R17
        nwords = 4'h0;
        for (int i = 0; i < `WORD_COUNT; i++) begin
            nwords = nwords + 4'(pres[i]);
        end
        w = `WORD_NONE;
        next_st = st;
        next_st.frame_done = 1'b0;
        next_st.dropped = 1'b0;
        case (st.phase)
            PH_IDLE: begin
                next_st.sample_ready = 1'b1;
                next_st.busy = 1'b0;
                if (sample_valid_in && st.sample_ready) begin
                    if (api_mode_in && (api_output_options_in ==
                            `API_OUTPUT_STANDARD)) begin // see R1, R2
                        next_st.phase = PH_HEADER;
                        next_st.sample_ready = 1'b0;
                        next_st.busy = 1'b1;
                        next_st.idx = `OFFSET_START;
                        next_st.sum = 8'h00;
                        next_st.low_half = 1'b0;
                        next_st.present = pres;
                        next_st.src_long = sample_in.src_long;
                        next_st.src_net = sample_in.src_net;
                        next_st.options = 8'h00;
                        next_st.options[`OPT_ACKED_BIT] =
                            sample_in.acked; // see R10
                        next_st.options[`OPT_BROADCAST_BIT] =
                            sample_in.broadcast; // see R10
                        next_st.sample_count =
                            sample_in.sample_count; // see R11
                        next_st.dig_mask = dmask; // see R12
                        next_st.ana_mask = amask; // see R13
                        // Unsampled lines forced low
                        next_st.words[`WORD_DIGITAL] =
                            sample_in.dig_samples & dmask; // see R15
                        for (int i = 0; i < `WORD_COUNT - 1; i++) begin
                            next_st.words[i + 1] = sample_in.ana_samples[i];
                        end
                        next_st.length = `FIXED_BODY_LENGTH +
                            {11'h000, nwords, 1'b0}; // see R5
                    end else begin
                        // Not standard API output: consumed, no frame
                        next_st.dropped = 1'b1; // see R2
                    end
                end
            end
            PH_HEADER: begin
                if (push) begin
                    if (st.idx >= `TYPE_OFFSET) begin
                        next_st.sum = st.sum + frame_byte; // see R18
                    end
                    if (st.idx == `HEADER_LAST) begin
                        w = next_word(st.present, `WORD_DIGITAL);
                        next_st.word = w;
                        next_st.low_half = 1'b0;
                        next_st.phase = (w == `WORD_NONE) ?
                            PH_CHECKSUM : PH_WORDS; // see R14
                    end else begin
                        next_st.idx = st.idx + 5'h01;
                    end
                end
            end
            PH_WORDS: begin
                if (push) begin
                    next_st.sum = st.sum + frame_byte; // see R18
                    if (!st.low_half) begin
                        next_st.low_half = 1'b1;
                    end else begin
                        // Ascending word order puts supply last
                        w = next_word(st.present,
                                      st.word + 3'h1); // see R16, R17
                        next_st.word = w;
                        next_st.low_half = 1'b0;
                        if (w == `WORD_NONE) begin
                            next_st.phase = PH_CHECKSUM;
                        end
                    end
                end
            end
            PH_CHECKSUM: begin
                if (push) begin
                    next_st.phase = PH_IDLE;
                    next_st.frame_done = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.sample_ready = 1'b1;
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Serial side may stall; the builder waits on the FIFO's ready
    sample_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .in_valid_in(push),
        .in_data_in(frame_byte),
        .in_ready_out(fifo_ready),
        .out_valid_out(tx_valid_out),
        .out_data_out(tx_data_out),
        .out_ready_in(tx_ready_in)
    );

    assign sample_ready_out = st.sample_ready;
    assign busy_out = st.busy;
    assign frame_done_out = st.frame_done;
    assign frame_dropped_out = st.dropped;
endmodule

`default_nettype wire

/* tb/io_sample_frame_builder_sva.sv */
// Port checks for the I/O sample frame builder
`timescale 1ns/1ps
`default_nettype none
module io_sample_frame_builder_chk
    import io_sample_frame_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic api_mode_in,
    input wire logic [7:0] api_output_options_in,
    input wire logic sample_valid_in,
    input wire io_sample_t sample_in,
    input wire logic sample_ready_out,
    input wire logic [7:0] tx_data_out,
    input wire logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic busy_out,
    input wire logic frame_done_out,
    input wire logic frame_dropped_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic take;
    logic fwd;
    assign take = sample_valid_in && sample_ready_out;
    assign fwd = api_mode_in && (api_output_options_in == 8'h00);
    // Quiet output path only, so the first byte out is ours
    property p_start_byte;
        take && fwd && !tx_valid_out && !frame_done_out
            && !$past(frame_done_out) |-> ##3 tx_valid_out
            && tx_data_out == 8'h7E;
    endproperty
    a_start_byte: assert property (p_start_byte)
        else $error("frame did not open with the start byte");
    property p_accept;
        take && fwd |=> busy_out && !sample_ready_out;
    endproperty
    a_accept: assert property (p_accept)
        else $error("accepted sample did not start a frame");
    property p_drop;
        take && !fwd |=> frame_dropped_out && sample_ready_out && !busy_out;
    endproperty
    a_drop: assert property (p_drop)
        else $error("sample outside API standard output not dropped");
    property p_drop_cause;
        frame_dropped_out |-> $past(take) && !$past(fwd);
    endproperty
    a_drop_cause: assert property (p_drop_cause)
        else $error("drop pulse without a refused sample");
    property p_hold;
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte changed before it was taken");
    property p_done_ready;
        frame_done_out |-> ##[0:1] sample_ready_out;
    endproperty
    a_done_ready: assert property (p_done_ready)
        else $error("ready did not return after frame end");
    property p_done_pulse;
        frame_done_out |=> !frame_done_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("frame done longer than one cycle");
    property p_busy_end;
        $fell(busy_out) |-> frame_done_out || $past(frame_done_out);
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy ended without a checksum");
    property p_busy_excl;
        busy_out |-> !sample_ready_out;
    endproperty
    a_busy_excl: assert property (p_busy_excl)
        else $error("ready while a frame is built");
endmodule
bind io_sample_frame_builder io_sample_frame_builder_chk #(
    .FIFO_DEPTH(FIFO_DEPTH)
) u_chk (.clock_in(clock_in), .rst_in(rst_in), .api_mode_in(api_mode_in),
    .api_output_options_in(api_output_options_in),
    .sample_valid_in(sample_valid_in), .sample_in(sample_in),
    .sample_ready_out(sample_ready_out), .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .busy_out(busy_out), .frame_done_out(frame_done_out),
    .frame_dropped_out(frame_dropped_out));
`default_nettype wire

/* tb/serial_host_model.sv */
// Host on the serial side, taking bytes with optional stalls
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    input wire logic stall_in,
    output logic tx_ready_out,
    output logic got_out,
    output logic [7:0] got_byte_out
);
    // Slow mode takes one byte in four so the FIFO fills
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            tx_ready_out <= 1'b0;
            got_out <= 1'b0;
            got_byte_out <= 8'h00;
        end else begin
            got_out <= tx_valid_in && tx_ready_out;
            got_byte_out <= tx_data_in;
            tx_ready_out <= !stall_in || ($urandom_range(3) == 0);
        end
    end
endmodule
`default_nettype wire

/* tb/tb_io_sample_frame_builder.sv */
// Self-checking bench for the I/O sample frame builder
`timescale 1ns/1ps
`default_nettype none
module tb_io_sample_frame_builder import io_sample_frame_pkg::*; ;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic api_mode_in = 1'b0;
    logic sample_valid_in = 1'b0;
    logic stall = 1'b0;
    logic [7:0] opts = 8'h00;
    io_sample_t smp = '0;
    logic ready, tx_valid, tx_ready, busy, done, drop, got;
    logic [7:0] tx_data, got_byte;
    int miscompares = 0;
    int checked = 0;
    int drops_exp = 0;
    int drops_seen = 0;
    int frames_exp = 0;
    int frames_seen = 0;
    logic [7:0] exp_q[$];
    always #20 clock_in = ~clock_in;
    io_sample_frame_builder DUT (.clock_in(clock_in), .rst_in(rst_in),
        .api_mode_in(api_mode_in), .api_output_options_in(opts),
        .sample_valid_in(sample_valid_in), .sample_in(smp),
        .sample_ready_out(ready), .tx_data_out(tx_data),
        .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .busy_out(busy),
        .frame_done_out(done), .frame_dropped_out(drop));
    serial_host_model host (.clock_in(clock_in), .rst_in(rst_in),
        .tx_valid_in(tx_valid), .tx_data_in(tx_data), .stall_in(stall),
        .tx_ready_out(tx_ready), .got_out(got), .got_byte_out(got_byte));
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic void w16(ref logic [7:0] q[$], input logic [15:0] v);
        q.push_back(v[15:8]);
        q.push_back(v[7:0]);
    endfunction
    // Expected frame bytes, worked out field by field
    function automatic void note(input io_sample_t s);
        logic [7:0] b[$];
        logic [15:0] dm;
        logic [7:0] am;
        logic [7:0] sum;
        dm = s.dig_mask & 16'h7FFF;
        am = s.ana_mask & 8'h8F;
        sum = 8'h00;
        b.push_back(8'h92);
        for (int i = 7; i >= 0; i--) b.push_back(s.src_long[i*8+:8]);
        w16(b, s.src_net);
        b.push_back({6'h00, s.broadcast, s.acked});
        b.push_back(s.sample_count);
        w16(b, dm);
        b.push_back(am);
        if (dm != 16'h0000) w16(b, s.dig_samples & dm);
        for (int i = 0; i < 4; i++) if (am[i]) w16(b, s.ana_samples[i]);
        if (am[7]) w16(b, s.ana_samples[4]);
        exp_q.push_back(8'h7E);
        w16(exp_q, 16'(b.size()));
        foreach (b[i]) begin
            exp_q.push_back(b[i]);
            sum += b[i];
        end
        exp_q.push_back(8'hFF - sum);
    endfunction
    task automatic send(input io_sample_t s, input logic api,
                        input logic [7:0] o);
        int n;
        n = 0;
        @(posedge clock_in);
        #1;
        smp = s;
        api_mode_in = api;
        opts = o;
        sample_valid_in = 1'b1;
        if (api && o == 8'h00) begin
            note(s);
            frames_exp++;
        end else begin
            drops_exp++;
        end
        while (ready !== 1'b1 && n < 5000) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        if (n >= 5000) miscompares++;
        @(posedge clock_in);
        #1 sample_valid_in = 1'b0;
    endtask
    // Sample at the falling edge, where registered outputs are settled
    always @(negedge clock_in) begin
        logic [7:0] e;
        if (got === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
            cmp8(got_byte, e);
        end
        if (drop === 1'b1) drops_seen++;
        if (done === 1'b1) frames_seen++;
    end
    initial begin
        #1_000_000;
        miscompares++;
        wrap_up();
    end
    initial begin
        io_sample_t s;
        logic [223:0] r;
        int n;
        void'($urandom(56821));
        repeat (20) @(posedge clock_in);
        #1 rst_in = 1'b0;
        s = '0;
        s.src_long = 64'h0011223344556677; // Arbitrary source address
        s.src_net = 16'h87AC;
        s.acked = 1'b1;
        s.sample_count = 8'h01;
        s.dig_mask = 16'h0038;
        s.ana_mask = 8'h06;
        s.dig_samples = 16'h0028;
        s.ana_samples[1] = 16'h0225;
        s.ana_samples[2] = 16'h00F8;
        send(s, 1'b1, 8'h00);
        send(s, 1'b0, 8'h00);
        send(s, 1'b1, 8'h01);
        for (int k = 0; k < 14; k++) begin
            for (int j = 0; j < 7; j++) r[j*32+:32] = $urandom();
            s = r[$bits(io_sample_t)-1:0];
            s.acked = k[0];
            s.broadcast = k[1];
            if (k == 1) {s.dig_mask, s.ana_mask} = 24'h000000;
            if (k == 2) {s.dig_mask, s.ana_mask} = 24'hFFFFFF;
            if (k == 3) s.dig_mask = 16'h8000;
            stall = k[0];
            send(s, 1'b1, 8'h00);
        end
        n = 0;
        while ((exp_q.size() != 0 || busy === 1'b1) && n < 20000) begin
            @(posedge clock_in);
            n++;
        end
        if (n >= 20000) miscompares++;
        cmp8(drops_seen[7:0], drops_exp[7:0]);
        cmp8(frames_seen[7:0], frames_exp[7:0]);
        wrap_up();
    end
endmodule
`default_nettype wire
